// ===== include/uvt_defs.svh
// named offsets, field positions and reset values of the uv readout block
// assumes inclusion by bare name from the package and the rtl files
`ifndef UVT_DEFS_SVH
`define UVT_DEFS_SVH

// register indices; byte address on apb is four times the index
`define UVT_IDX_PIN_CFG 8'h22
`define UVT_IDX_IRQ_SETUP 8'h23
`define UVT_IDX_EVENT_FLAGS 8'h24
`define UVT_IDX_THRESHOLD 8'h25
`define UVT_IDX_STATUS 8'h27
`define UVT_IDX_RESULT 8'h28
`define UVT_IDX_IRQ_STATUS 8'h30
`define UVT_IDX_IRQ_MASK 8'h31

// apb address slicing
`define UVT_ADDR_W 12
`define UVT_IDX_LSB 2
`define UVT_IDX_MSB 9

// irq_setup fields
`define UVT_SETUP_HIGH_EN 0
`define UVT_SETUP_LOW_EN 1
`define UVT_SETUP_LATCH 2
`define UVT_SETUP_MASTER 3
`define UVT_SETUP_MASK 8'h0F

// irq_event_flags fields
`define UVT_FLAG_HIGH 0
`define UVT_FLAG_LOW 1
`define UVT_FLAG_PEND 2

// sample_status fields
`define UVT_STATUS_NEW 0

// pin configuration fields
`define UVT_PIN_ROUTE_LSB 0
`define UVT_PIN_ROUTE_MSB 1
`define UVT_PIN_POL 7
`define UVT_PIN_MASK 8'h83

// pin routing codes
`define UVT_ROUTE_DRDY 2'h0
`define UVT_ROUTE_HIGH 2'h1
`define UVT_ROUTE_LOW 2'h2
`define UVT_ROUTE_EITHER 2'h3

// interrupt status and mask fields
`define UVT_IRQ_SAMPLE 0
`define UVT_IRQ_HIGH 1
`define UVT_IRQ_LOW 2
`define UVT_IRQ_MASK_BITS 8'h07

// reset values
`define UVT_RST_BYTE 8'h00
`define UVT_RST_WORD 32'h0000_0000

`endif

// ===== include/uvt_pkg.sv
// types and shared decoding of the uv readout block
// assumes uvt_defs.svh is on the include path
`include "uvt_defs.svh"

package uvt_pkg;

	typedef logic [7:0] uvt_byte_t;
	typedef logic [`UVT_ADDR_W-1:0] uvt_addr_t;
	typedef logic [1:0] uvt_route_t;

	// register index from a byte address; used by slave and read mux
	function automatic uvt_byte_t uvtIndex(input uvt_addr_t addr);
		uvtIndex = addr[`UVT_IDX_MSB:`UVT_IDX_LSB];
	endfunction

	// true when the address is word aligned, bits above the index are zero and the index names a register of this block
	function automatic logic uvtMapped(input uvt_addr_t addr);
		uvt_byte_t idx;
		idx = uvtIndex(addr);
		uvtMapped = (addr[`UVT_IDX_LSB-1:0] == 2'h0) && (addr[`UVT_ADDR_W-1:`UVT_IDX_MSB+1] == 2'h0) &&
			(idx == `UVT_IDX_PIN_CFG || idx == `UVT_IDX_IRQ_SETUP || idx == `UVT_IDX_EVENT_FLAGS ||
			idx == `UVT_IDX_THRESHOLD || idx == `UVT_IDX_STATUS || idx == `UVT_IDX_RESULT ||
			idx == `UVT_IDX_IRQ_STATUS || idx == `UVT_IDX_IRQ_MASK);
	endfunction

endpackage

// ===== rtl/uvt_apb_slave.sv
// apb slave front end: no wait state, registered answer
// assumes the caller supplies combinational read data for the current address
`timescale 1ns/1ns
`include "uvt_defs.svh"

module uvt_apb_slave (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire uvt_pkg::uvt_addr_t paddr,
	input wire logic [31:0] pwdata,
	input wire uvt_pkg::uvt_byte_t rdData,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output logic wrStrobe,
	output logic rdStrobe,
	output uvt_pkg::uvt_byte_t regIdx,
	output uvt_pkg::uvt_byte_t wrByte
);
	import uvt_pkg::*;

	logic readyD, readyQ, errD, errQ;
	logic [31:0] rdataD, rdataQ;
	logic setup, done;

	// answer is prepared in the setup cycle so pready, pslverr and prdata are flops
	always_comb begin
		setup = psel && !penable;
		done = psel && penable && readyQ;
		readyD = setup;
		errD = setup ? !uvtMapped(paddr) : 1'b0;
		rdataD = rdataQ;
		if (setup) begin
			rdataD = (!pwrite && uvtMapped(paddr)) ? {24'h00_0000, rdData} : `UVT_RST_WORD;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			readyQ <= 1'b0;
			errQ <= 1'b0;
			rdataQ <= `UVT_RST_WORD;
		end else begin
			readyQ <= readyD;
			errQ <= errD;
			rdataQ <= rdataD;
		end
	end

	// effects happen only on the completing edge, and never for an unmapped address
	assign wrStrobe = done && pwrite && !errQ;
	assign rdStrobe = done && !pwrite && !errQ;
	assign regIdx = uvtIndex(paddr);
	assign wrByte = pwdata[7:0];
	assign pready = readyQ;
	assign pslverr = errQ;
	assign prdata = rdataQ;
endmodule

// ===== rtl/uvt_event_pin.sv
// event pin driver: source routing and polarity, registered output
// assumes flag inputs are on the same clock as this module
`timescale 1ns/1ns
`include "uvt_defs.svh"

module uvt_event_pin (
	input wire logic clk,
	input wire logic sys_rst,
	input wire uvt_pkg::uvt_route_t route,
	input wire logic activeLow,
	input wire logic dataReady,
	input wire logic highFlag,
	input wire logic lowFlag,
	output logic eventPin
);
	import uvt_pkg::*;

	logic levelRaw, pinD, pinQ;

	// routing select then polarity
	always_comb begin
		unique case (route)
			`UVT_ROUTE_DRDY: levelRaw = dataReady;
			`UVT_ROUTE_HIGH: levelRaw = highFlag;
			`UVT_ROUTE_LOW: levelRaw = lowFlag;
			`UVT_ROUTE_EITHER: levelRaw = highFlag || lowFlag;
		endcase
		pinD = levelRaw ^ activeLow;
	end

	// reset shows the inactive level for the default active-high setting
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinQ <= 1'b0;
		end else begin
			pinQ <= pinD;
		end
	end

	assign eventPin = pinQ;
endmodule

// ===== rtl/uvt_readout_top.sv
// uv index readout: result, new-sample flag, threshold events, event pin, irq
// assumes samples arrive as a one-cycle strobe on clk from the measurement logic
//
// Contract
// - threshold events are produced only while the master interrupt enable is one, default zero.
// - with the latch option set, event requests are held in the event flags register, otherwise not.
// - with the low-event enable set, a sample below the threshold raises a low event.
// - with the high-event enable set, a sample above the threshold raises a high event.
// - bit 2 of the event flags reads one when any event has been generated, default zero.
// - bit 1 of the event flags reads one after a low event, default zero.
// - bit 0 of the event flags reads one after a high event, default zero; upper bits are void.
// - the host programs an 8-bit threshold that serves both high and low comparisons.
// - the new-sample flag at status bit 0 is set on every new sample.
// - reading the result register clears the new-sample flag.
// - the latest uv index is shown as an 8-bit read-only result.
// - a two-bit routing field picks data ready, high, low or either event for the pin.
// - a polarity bit makes the pin active high at zero (default) and active low at one.
`timescale 1ns/1ns
`include "uvt_defs.svh"

module uvt_readout_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire uvt_pkg::uvt_addr_t paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic sampleStrobe,
	input wire uvt_pkg::uvt_byte_t sampleValue,
	output logic eventPin,
	output logic irq
);
	import uvt_pkg::*;

	uvt_byte_t rdData, regIdx, wrByte;
	logic wrStrobe, rdStrobe;

	// apb front end
	uvt_apb_slave uApb (
		.clk(clk),
		.sys_rst(sys_rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.rdData(rdData),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe),
		.regIdx(regIdx),
		.wrByte(wrByte)
	);

	// ---- configuration registers written by software
	uvt_byte_t setup_q, setup_d;
	uvt_byte_t threshold_q, threshold_d;
	uvt_byte_t pinCfg_q, pinCfg_d;
	uvt_byte_t irqMask_q, irqMask_d;

	// only implemented bits take a write; the rest stay zero
	always_comb begin
		setup_d = setup_q;
		threshold_d = threshold_q;
		pinCfg_d = pinCfg_q;
		irqMask_d = irqMask_q;
		if (wrStrobe) begin
			unique case (regIdx)
				`UVT_IDX_IRQ_SETUP: setup_d = wrByte & `UVT_SETUP_MASK;
				`UVT_IDX_THRESHOLD: threshold_d = wrByte;
				`UVT_IDX_PIN_CFG: pinCfg_d = wrByte & `UVT_PIN_MASK;
				`UVT_IDX_IRQ_MASK: irqMask_d = wrByte & `UVT_IRQ_MASK_BITS;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			setup_q <= `UVT_RST_BYTE;
			threshold_q <= `UVT_RST_BYTE;
			pinCfg_q <= `UVT_RST_BYTE;
			irqMask_q <= `UVT_RST_BYTE;
		end else begin
			setup_q <= setup_d;
			threshold_q <= threshold_d;
			pinCfg_q <= pinCfg_d;
			irqMask_q <= irqMask_d;
		end
	end

	logic irqMasterEnable, latchRequestSelect, lowEventEnable, highEventEnable;
	assign irqMasterEnable = setup_q[`UVT_SETUP_MASTER];
	assign latchRequestSelect = setup_q[`UVT_SETUP_LATCH];
	assign lowEventEnable = setup_q[`UVT_SETUP_LOW_EN];
	assign highEventEnable = setup_q[`UVT_SETUP_HIGH_EN];

	// ---- result and new-sample flag
	uvt_byte_t uvIndexResult_q, uvIndexResult_d;
	logic newSampleFlag_q, newSampleFlag_d;
	logic resultRead;

	assign resultRead = rdStrobe && (regIdx == `UVT_IDX_RESULT);

	// a sample landing on the clearing read keeps the flag set, so it is never lost
	always_comb begin
		uvIndexResult_d = uvIndexResult_q;
		newSampleFlag_d = newSampleFlag_q;
		if (resultRead) begin
			newSampleFlag_d = 1'b0;
		end
		if (sampleStrobe) begin
			uvIndexResult_d = sampleValue;
			newSampleFlag_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			uvIndexResult_q <= `UVT_RST_BYTE;
			newSampleFlag_q <= 1'b0;
		end else begin
			uvIndexResult_q <= uvIndexResult_d;
			newSampleFlag_q <= newSampleFlag_d;
		end
	end

	// ---- threshold events
	logic highEventFlag_q, highEventFlag_d, lowEventFlag_q, lowEventFlag_d;
	logic highHit, lowHit, flagsRead;

	// compares against the new value, so the event matches the result it is read with
	always_comb begin
		highHit = sampleStrobe && irqMasterEnable && highEventEnable && (sampleValue > threshold_q);
		lowHit = sampleStrobe && irqMasterEnable && lowEventEnable && (sampleValue < threshold_q);
	end

	assign flagsRead = rdStrobe && (regIdx == `UVT_IDX_EVENT_FLAGS);

	// latched flags clear on a read of the flags register; set beats that clear
	always_comb begin
		highEventFlag_d = highEventFlag_q;
		lowEventFlag_d = lowEventFlag_q;
		if (latchRequestSelect) begin
			if (flagsRead) begin
				highEventFlag_d = 1'b0;
				lowEventFlag_d = 1'b0;
			end
			if (highHit) begin
				highEventFlag_d = 1'b1;
			end
			if (lowHit) begin
				lowEventFlag_d = 1'b1;
			end
		end else if (sampleStrobe) begin
			// unlatched: flags follow the most recent comparison only
			highEventFlag_d = highHit;
			lowEventFlag_d = lowHit;
		end
		if (!irqMasterEnable) begin
			// disabling the circuit also drops what it had raised
			highEventFlag_d = 1'b0;
			lowEventFlag_d = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			highEventFlag_q <= 1'b0;
			lowEventFlag_q <= 1'b0;
		end else begin
			highEventFlag_q <= highEventFlag_d;
			lowEventFlag_q <= lowEventFlag_d;
		end
	end

	logic interruptPendingFlag;
	assign interruptPendingFlag = highEventFlag_q || lowEventFlag_q;

	// ---- sticky interrupt status, write one to clear
	uvt_byte_t irqStatus_q, irqStatus_d;
	uvt_byte_t irqEvents, irqClear;
	logic irq_q, irq_d;

	always_comb begin
		irqEvents = `UVT_RST_BYTE;
		irqEvents[`UVT_IRQ_SAMPLE] = sampleStrobe;
		irqEvents[`UVT_IRQ_HIGH] = highHit;
		irqEvents[`UVT_IRQ_LOW] = lowHit;
		irqClear = (wrStrobe && regIdx == `UVT_IDX_IRQ_STATUS) ? wrByte : `UVT_RST_BYTE;
		// new events win over a clear in the same cycle
		irqStatus_d = ((irqStatus_q & ~irqClear) | irqEvents) & `UVT_IRQ_MASK_BITS;
		irq_d = |(irqStatus_d & irqMask_q);
	end

	// irq tracks next status so it falls on the clearing edge itself
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqStatus_q <= `UVT_RST_BYTE;
			irq_q <= 1'b0;
		end else begin
			irqStatus_q <= irqStatus_d;
			irq_q <= irq_d;
		end
	end

	assign irq = irq_q;

	// ---- event pin
	uvt_event_pin uPin (
		.clk(clk),
		.sys_rst(sys_rst),
		.route(pinCfg_q[`UVT_PIN_ROUTE_MSB:`UVT_PIN_ROUTE_LSB]),
		.activeLow(pinCfg_q[`UVT_PIN_POL]),
		.dataReady(newSampleFlag_q),
		.highFlag(highEventFlag_q),
		.lowFlag(lowEventFlag_q),
		.eventPin(eventPin)
	);

	// ---- read mux; unused bits read zero
	always_comb begin
		rdData = `UVT_RST_BYTE;
		unique case (regIdx)
			`UVT_IDX_PIN_CFG: rdData = pinCfg_q;
			`UVT_IDX_IRQ_SETUP: rdData = setup_q;
			`UVT_IDX_EVENT_FLAGS: begin
				rdData[`UVT_FLAG_HIGH] = highEventFlag_q;
				rdData[`UVT_FLAG_LOW] = lowEventFlag_q;
				rdData[`UVT_FLAG_PEND] = interruptPendingFlag;
			end
			`UVT_IDX_THRESHOLD: rdData = threshold_q;
			`UVT_IDX_STATUS: rdData[`UVT_STATUS_NEW] = newSampleFlag_q;
			`UVT_IDX_RESULT: rdData = uvIndexResult_q;
			`UVT_IDX_IRQ_STATUS: rdData = irqStatus_q;
			`UVT_IDX_IRQ_MASK: rdData = irqMask_q;
			default: ;
		endcase
	end
endmodule

// ===== test/uvt_readout_asserts.sv
// checker of apb answers and of mirrored setup, threshold and pin config
// assumes it is bound to uvt_readout_top; one clock
`timescale 1ns/1ns
`include "uvt_defs.svh"
module uvt_readout_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire uvt_pkg::uvt_addr_t paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic eventPin
);
	import uvt_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	uvt_byte_t thr_q;
	uvt_byte_t setup_q;
	uvt_byte_t pin_q;
	logic wrAcc;
	logic rdAcc;
	// mirrors follow completed writes to their own mapped addresses only, so refused cycles leave them alone
	assign wrAcc = psel && penable && pready && pwrite;
	assign rdAcc = pready && !pwrite;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			thr_q <= 8'h00;
			setup_q <= 8'h00;
			pin_q <= 8'h00;
		end else if (wrAcc && paddr == 12'h094) begin
			thr_q <= pwdata[7:0];
		end else if (wrAcc && paddr == 12'h08C) begin
			setup_q <= pwdata[7:0] & `UVT_SETUP_MASK;
		end else if (wrAcc && paddr == 12'h088) begin
			pin_q <= pwdata[7:0] & `UVT_PIN_MASK;
		end
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
	a_ready_single_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_err_misaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
		else $error("misaligned access not refused");
	a_result_width: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read lanes set");
	a_thr_readback: assert property (rdAcc && paddr == 12'h094 |-> prdata[7:0] == thr_q)
		else $error("threshold readback differs");
	a_setup_readback: assert property (rdAcc && paddr == 12'h08C |-> prdata[7:0] == setup_q)
		else $error("setup readback differs");
	a_flags_upper_void: assert property (rdAcc && paddr == 12'h090 |-> prdata[7:3] == 5'h0)
		else $error("void flag bits set");
	a_status_upper_void: assert property (rdAcc && paddr == 12'h09C |-> prdata[7:1] == 7'h0)
		else $error("void status bits set");
	a_pin_idle_level: assert property ((!setup_q[3] && pin_q[1:0] != 2'h0) [*3] |-> eventPin == pin_q[7])
		else $error("event pin active with master off");
	c_refused: cover property (pready && pslverr);
	c_thr_write: cover property (wrAcc && paddr == 12'h094);
	c_pin_low_active: cover property (pin_q[7] && !eventPin);
endmodule
bind uvt_readout_top uvt_readout_asserts chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.eventPin(eventPin));

// ===== test/uvt_host_model.sv
// host side apb master model with one transfer task
// assumes the readout block shares its clock
`timescale 1ns/1ns
module uvt_host_model (
	input wire logic clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output uvt_pkg::uvt_addr_t paddr,
	output logic [31:0] pwdata
);
	import uvt_pkg::*;
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// request held until pready is seen high at a rising edge, no fixed wait
	task automatic xfer(input logic wr, input uvt_addr_t a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ===== test/uv_index_threshold_irq_readout_tb.sv
// self-checking bench of the uv readout block over apb
// assumes host model and checker are compiled before it
`timescale 1ns/1ns
module uv_index_threshold_irq_readout_tb;
	import uvt_pkg::*;
	logic clk, sys_rst, sampleStrobe, psel, penable, pwrite, pready, pslverr, eventPin, irq, rdErr, irqA, pinExp;
	uvt_byte_t sampleValue;
	uvt_addr_t paddr;
	logic [31:0] pwdata, prdata, rdData;
	int num_errors, checked;
	uvt_addr_t regs [8] = '{12'h088, 12'h08C, 12'h090, 12'h094, 12'h09C, 12'h0A0, 12'h0C0, 12'h0C4};
	uvt_readout_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.sampleStrobe(sampleStrobe), .sampleValue(sampleValue), .eventPin(eventPin), .irq(irq));
	uvt_host_model host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input uvt_addr_t a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rdData, rdErr);
	endtask
	task automatic rd(input uvt_addr_t a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, rdData, rdErr);
		check($sformatf("reg %h", a), exp, rdData);
	endtask
	// one-cycle strobe, then one edge so the pin can follow
	task automatic smp(input uvt_byte_t v);
		@(posedge clk);
		sampleStrobe <= 1'b1;
		sampleValue <= v;
		@(posedge clk);
		sampleStrobe <= 1'b0;
		@(posedge clk);
	endtask
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the sequence needs
	initial begin
		#200000;
		num_errors++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		sampleStrobe = 1'b0;
		sampleValue = 8'h00;
		num_errors = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (regs[i]) rd(regs[i], 32'h0);
		rd(12'h098, 32'h0);
		check("pslverr", 32'h1, {31'h0, rdErr});
		wr(12'h094, 32'h80);
		rd(12'h094, 32'h80);
		wr(12'h0A0, 32'h55);
		rd(12'h0A0, 32'h0);
		// own enables alone raise nothing
		wr(12'h08C, 32'h03);
		smp(8'h90);
		rd(12'h090, 32'h0);
		rd(12'h09C, 32'h1);
		rd(12'h0A0, 32'h90);
		rd(12'h09C, 32'h0);
		// unlatched: flags follow each sample, equal value is no event
		wr(12'h08C, 32'h0B);
		smp(8'h90);
		rd(12'h090, 32'h05);
		smp(8'h10);
		rd(12'h090, 32'h06);
		smp(8'h80);
		rd(12'h090, 32'h0);
		// latched: held until flags are read
		wr(12'h08C, 32'h0F);
		smp(8'h90);
		smp(8'h80);
		rd(12'h090, 32'h05);
		rd(12'h090, 32'h0);
		wr(12'h08C, 32'h0E);
		smp(8'h90);
		rd(12'h090, 32'h0);
		smp(8'h10);
		rd(12'h090, 32'h06);
		// every route and polarity against a high and a low sample
		wr(12'h08C, 32'h0B);
		for (int p = 0; p < 2; p++) for (int r = 0; r < 4; r++) for (int v = 0; v < 2; v++) begin
			wr(12'h088, {24'h0, p[0], 5'h0, r[1:0]});
			smp(v[0] ? 8'h10 : 8'h90);
			@(posedge clk);
			#1;
			pinExp = (r == 0 || r == 3 || r == v + 1) ^ p[0];
			check("eventPin", {31'h0, pinExp}, {31'h0, eventPin});
		end
		wr(12'h08C, 32'h00);
		repeat (3) @(posedge clk);
		#1;
		check("eventPin", 32'h1, {31'h0, eventPin});
		// sticky irq status, mask decides the line
		wr(12'h0C4, 32'h07);
		rd(12'h0C4, 32'h07);
		wr(12'h0C0, 32'h07);
		rd(12'h0C0, 32'h0);
		check("irq", 32'h0, {31'h0, irq});
		smp(8'h90);
		rd(12'h0C0, 32'h01);
		irqA = irq;
		wr(12'h0C4, 32'h00);
		@(posedge clk);
		#1;
		check("irq before mask", 32'h1, {31'h0, irqA});
		check("irq mask", 32'h0, {31'h0, irq});
		wr(12'h0C0, 32'h01);
		@(posedge clk);
		#1;
		check("irq", 32'h0, {31'h0, irq});
		test_done();
	end
endmodule
